// ### src/peak_tamper_pkg.sv
// constants, register map and carrier types for the peak and tamper monitor
package peak_tamper_pkg;

  // ----------------------------------------------------------------------
  // register word offsets (byte addresses, one 32-bit word each)
  // ----------------------------------------------------------------------
  localparam logic [7:0] voltage_peak_result_off = 8'h00;
  localparam logic [7:0] current_peak_result_off = 8'h04;
  localparam logic [7:0] overvoltage_threshold_off = 8'h08;
  localparam logic [7:0] overcurrent_threshold_off = 8'h0C;
  localparam logic [7:0] phase_current_sum_off = 8'h10;
  localparam logic [7:0] sum_mismatch_threshold_off = 8'h14;
  localparam logic [7:0] peak_window_count_off = 8'h18;
  localparam logic [7:0] measurement_mode_off = 8'h1C;
  localparam logic [7:0] second_status_off = 8'h20;
  localparam logic [7:0] second_mask_off = 8'h24;
  localparam logic [7:0] phase_status_off = 8'h28;
  localparam logic [7:0] first_status_off = 8'h2C;

  // ----------------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------------
  localparam int peak_value_lsb = 0;
  localparam int peak_tag_lsb = 24;
  localparam int peak_select_lsb = 2;
  localparam int overcurrent_bit = 17;
  localparam int overvoltage_bit = 18;
  localparam int mismatch_bit = 20;
  localparam int current_peak_done_bit = 23;
  localparam int voltage_peak_done_bit = 24;
  localparam int overcurrent_phase_lsb = 3;
  localparam int overvoltage_phase_lsb = 9;
  localparam int dsp_done_bit = 17;

  // ----------------------------------------------------------------------
  // values after reset and sample scale
  // ----------------------------------------------------------------------
  localparam logic [23:0] full_scale_magnitude = 24'h51_4791;
  localparam logic [23:0] overvoltage_threshold_rst = 24'h51_4791;
  localparam logic [23:0] overcurrent_threshold_rst = 24'h51_4791;
  localparam logic [23:0] sum_mismatch_threshold_rst = 24'h00_0000;
  localparam logic [7:0] peak_window_count_rst = 8'h00;
  localparam logic [31:0] word_zero = 32'h0000_0000;

  // ----------------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [2:0][23:0] volt;
    logic [2:0][23:0] curr;
    logic [23:0] neutral;
  } wave_samples_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [31:0] wdata;
  } reg_req_t;

endpackage : peak_tamper_pkg

// ### src/waveform_peak_and_tamper_monitor.sv
// peak, over-level and neutral mismatch monitor of a three-phase metering front end
`timescale 1ns/1ps

module waveform_peak_and_tamper_monitor #(
  parameter int window_width = 8
) (
  input wire logic clock,
  input wire logic srst,
  input wire peak_tamper_pkg::wave_samples_t samples,
  input wire logic sample_valid,
  input wire logic [2:0] zero_cross,
  input wire peak_tamper_pkg::reg_req_t reg_req,
  output logic [31:0] reg_rdata,
  output logic reg_rvalid,
  output logic event_irq_n
);
  import peak_tamper_pkg::*;

  // ----------------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------------
  logic [23:0] voltage_peak_value;
  logic [2:0] voltage_peak_phase_tag;
  logic [23:0] current_peak_value;
  logic [2:0] current_peak_phase_tag;
  logic [23:0] overvoltage_threshold;
  logic [23:0] overcurrent_threshold;
  logic [27:0] phase_current_sum;
  logic [23:0] sum_mismatch_threshold;
  logic [window_width-1:0] peak_window_count;
  logic [2:0] peak_phase_select;
  logic [31:0] second_status_reg;
  logic [31:0] second_mask_reg;
  logic [2:0] overvoltage_phase_bits;
  logic [2:0] overcurrent_phase_bits;
  logic dsp_done_flag;

  // running window state
  logic [window_width-1:0] half_cycle_count;
  logic [23:0] run_volt_max;
  logic [2:0] run_volt_tag;
  logic [23:0] run_curr_max;
  logic [2:0] run_curr_tag;

  // ----------------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------------
  logic write_strobe;
  logic [31:0] clear_mask;
  logic clear_status;
  logic clear_first;

  assign write_strobe = reg_req.wr;
  assign clear_status = write_strobe && (reg_req.addr == second_status_off);
  assign clear_first = write_strobe && (reg_req.addr == first_status_off);
  assign clear_mask = clear_status ? reg_req.wdata : word_zero;

  // ----------------------------------------------------------------------
  // per-phase magnitudes and level comparisons
  // ----------------------------------------------------------------------
  logic [2:0][23:0] volt_mag;
  logic [2:0][23:0] curr_mag;
  logic [2:0] over_volt_hit;
  logic [2:0] over_curr_hit;

  function automatic logic [23:0] magnitude(input logic [23:0] value);
    magnitude = value[23] ? (~value + 24'h00_0001) : value;
  endfunction : magnitude

  // a zero threshold flags even a zero sample, so it detects continuously
  genvar ph;
  generate
    for (ph = 0; ph < 3; ph++) begin : g_phase
      assign volt_mag[ph] = magnitude(samples.volt[ph]);
      assign curr_mag[ph] = magnitude(samples.curr[ph]);
      assign over_volt_hit[ph] = sample_valid &&
        ((volt_mag[ph] > overvoltage_threshold) || (overvoltage_threshold == 24'h00_0000));
      assign over_curr_hit[ph] = sample_valid &&
        ((curr_mag[ph] > overcurrent_threshold) || (overcurrent_threshold == 24'h00_0000));
    end
  endgenerate

  // ----------------------------------------------------------------------
  // largest enabled sample of this cycle, the lower phase (A before B before C) wins a tie
  // ----------------------------------------------------------------------
  logic [23:0] cand_volt;
  logic [2:0] cand_volt_tag;
  logic [23:0] cand_curr;
  logic [2:0] cand_curr_tag;

  always_comb begin
    cand_volt = 24'h00_0000;
    cand_volt_tag = 3'b000;
    cand_curr = 24'h00_0000;
    cand_curr_tag = 3'b000;
    for (int i = 0; i < 3; i++) begin
      if (peak_phase_select[i] && (cand_volt_tag == 3'b000 || volt_mag[i] > cand_volt)) begin
        cand_volt = volt_mag[i];
        cand_volt_tag = 3'b001 << i;
      end
      if (peak_phase_select[i] && (cand_curr_tag == 3'b000 || curr_mag[i] > cand_curr)) begin
        cand_curr = curr_mag[i];
        cand_curr_tag = 3'b001 << i;
      end
    end
  end

  // ----------------------------------------------------------------------
  // half-line-cycle window timing
  // ----------------------------------------------------------------------
  logic [1:0] cross_inc;
  logic [window_width:0] count_sum;
  logic window_end;
  logic window_restart;

  // each enabled crossing counts, so more phases shorten the window
  assign cross_inc = 2'({1'b0, zero_cross[0] & peak_phase_select[0]} +
                        {1'b0, zero_cross[1] & peak_phase_select[1]} +
                        {1'b0, zero_cross[2] & peak_phase_select[2]});
  assign count_sum = {1'b0, half_cycle_count} + {{(window_width - 1){1'b0}}, cross_inc};
  assign window_end = (cross_inc != 2'b00) && (count_sum >= {1'b0, peak_window_count});
  assign window_restart = write_strobe && (reg_req.addr == peak_window_count_off) &&
                          (reg_req.wdata[peak_select_lsb +: 3] != 3'b000 ||
                           peak_phase_select != 3'b000) ? 1'b1 : 1'b0;

  // counter never stops; clears at each window end and on a window count write while a phase is enabled
  always_ff @(posedge clock) begin
    if (srst) begin
      half_cycle_count <= '0;
    end else if (window_restart && peak_phase_select != 3'b000) begin
      half_cycle_count <= '0;
    end else if (window_end) begin
      half_cycle_count <= '0;
    end else begin
      half_cycle_count <= count_sum[window_width-1:0];
    end
  end

  // ----------------------------------------------------------------------
  // running maxima over the open window
  // ----------------------------------------------------------------------
  logic volt_bigger;
  logic curr_bigger;
  assign volt_bigger = sample_valid && (cand_volt_tag != 3'b000) &&
                       (run_volt_tag == 3'b000 || cand_volt > run_volt_max);
  assign curr_bigger = sample_valid && (cand_curr_tag != 3'b000) &&
                       (run_curr_tag == 3'b000 || cand_curr > run_curr_max);

  // a sample in the closing cycle opens the next window rather than the old one
  always_ff @(posedge clock) begin
    if (srst) begin
      run_volt_max <= 24'h00_0000;
      run_volt_tag <= 3'b000;
      run_curr_max <= 24'h00_0000;
      run_curr_tag <= 3'b000;
    end else if (window_end || (window_restart && peak_phase_select != 3'b000)) begin
      run_volt_max <= sample_valid ? cand_volt : 24'h00_0000;
      run_volt_tag <= sample_valid ? cand_volt_tag : 3'b000;
      run_curr_max <= sample_valid ? cand_curr : 24'h00_0000;
      run_curr_tag <= sample_valid ? cand_curr_tag : 3'b000;
    end else begin
      if (volt_bigger) begin
        run_volt_max <= cand_volt;
        run_volt_tag <= cand_volt_tag;
      end
      if (curr_bigger) begin
        run_curr_max <= cand_curr;
        run_curr_tag <= cand_curr_tag;
      end
    end
  end

  // ----------------------------------------------------------------------
  // published peak results, touched only at a window end
  // ----------------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (srst) begin
      voltage_peak_value <= 24'h00_0000;
      voltage_peak_phase_tag <= 3'b000;
      current_peak_value <= 24'h00_0000;
      current_peak_phase_tag <= 3'b000;
    end else if (window_end) begin
      voltage_peak_value <= run_volt_max;
      voltage_peak_phase_tag <= run_volt_tag;
      current_peak_value <= run_curr_max;
      current_peak_phase_tag <= run_curr_tag;
    end
  end

  // ----------------------------------------------------------------------
  // phase current sum and neutral mismatch
  // ----------------------------------------------------------------------
  logic [27:0] next_sum;
  logic [27:0] sum_mag;
  logic [27:0] neutral_mag;
  logic [28:0] mag_diff;
  logic [27:0] diff_mag;
  logic [27:0] threshold_ext;
  logic mismatch_hit;

  assign next_sum = {{4{samples.curr[0][23]}}, samples.curr[0]} +
                    {{4{samples.curr[1][23]}}, samples.curr[1]} +
                    {{4{samples.curr[2][23]}}, samples.curr[2]};
  assign sum_mag = next_sum[27] ? (~next_sum + 28'h000_0001) : next_sum;
  assign neutral_mag = {4'h0, magnitude(samples.neutral)};
  assign mag_diff = {1'b0, sum_mag} - {1'b0, neutral_mag};
  assign diff_mag = mag_diff[28] ? 28'(~mag_diff + 29'h0000_0001) : mag_diff[27:0];
  assign threshold_ext = {{4{sum_mismatch_threshold[23]}}, sum_mismatch_threshold};
  // threshold at or below zero flags every sample
  assign mismatch_hit = sample_valid &&
    ((sum_mismatch_threshold[23] || sum_mismatch_threshold == 24'h00_0000) ||
     (diff_mag > threshold_ext));

  always_ff @(posedge clock) begin
    if (srst) begin
      phase_current_sum <= 28'h000_0000;
    end else if (sample_valid) begin
      phase_current_sum <= next_sum;
    end
  end

  // ready flag: set wins over a write-one clear in the same cycle
  always_ff @(posedge clock) begin
    if (srst) begin
      dsp_done_flag <= 1'b0;
    end else if (sample_valid) begin
      dsp_done_flag <= 1'b1;
    end else if (clear_first && reg_req.wdata[dsp_done_bit]) begin
      dsp_done_flag <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // sticky status, set wins over clear
  // ----------------------------------------------------------------------
  logic [31:0] status_set;
  always_comb begin
    status_set = word_zero;
    status_set[current_peak_done_bit] = window_end;
    status_set[voltage_peak_done_bit] = window_end;
    status_set[overvoltage_bit] = |over_volt_hit;
    status_set[overcurrent_bit] = |over_curr_hit;
    status_set[mismatch_bit] = mismatch_hit;
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      second_status_reg <= word_zero;
    end else begin
      second_status_reg <= (second_status_reg & ~clear_mask) | status_set;
    end
  end

  // phase bits follow their summary bit's write-one clear
  always_ff @(posedge clock) begin
    if (srst) begin
      overvoltage_phase_bits <= 3'b000;
    end else if (clear_mask[overvoltage_bit]) begin
      overvoltage_phase_bits <= over_volt_hit;
    end else begin
      overvoltage_phase_bits <= overvoltage_phase_bits | over_volt_hit;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      overcurrent_phase_bits <= 3'b000;
    end else if (clear_mask[overcurrent_bit]) begin
      overcurrent_phase_bits <= over_curr_hit;
    end else begin
      overcurrent_phase_bits <= overcurrent_phase_bits | over_curr_hit;
    end
  end

  // registered pin, one cycle behind status; low while any masked bit stands
  always_ff @(posedge clock) begin
    if (srst) begin
      event_irq_n <= 1'b1;
    end else begin
      event_irq_n <= ~|(second_status_reg & second_mask_reg);
    end
  end

  // ----------------------------------------------------------------------
  // writable configuration
  // ----------------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (srst) begin
      overvoltage_threshold <= overvoltage_threshold_rst;
      overcurrent_threshold <= overcurrent_threshold_rst;
      sum_mismatch_threshold <= sum_mismatch_threshold_rst;
      peak_window_count <= window_width'(peak_window_count_rst);
      peak_phase_select <= 3'b000;
      second_mask_reg <= word_zero;
    end else if (write_strobe) begin
      case (reg_req.addr)
        overvoltage_threshold_off: overvoltage_threshold <= reg_req.wdata[23:0];
        overcurrent_threshold_off: overcurrent_threshold <= reg_req.wdata[23:0];
        sum_mismatch_threshold_off: sum_mismatch_threshold <= reg_req.wdata[23:0];
        peak_window_count_off: peak_window_count <= reg_req.wdata[window_width-1:0];
        measurement_mode_off: peak_phase_select <= reg_req.wdata[peak_select_lsb +: 3];
        second_mask_off: second_mask_reg <= reg_req.wdata;
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // read port: data one cycle after the read strobe, unmapped reads zero
  // ----------------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (srst) begin
      reg_rdata <= word_zero;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_req.rd;
      if (reg_req.rd) begin
        case (reg_req.addr)
          voltage_peak_result_off: reg_rdata <= {5'h00, voltage_peak_phase_tag, voltage_peak_value};
          current_peak_result_off: reg_rdata <= {5'h00, current_peak_phase_tag, current_peak_value};
          overvoltage_threshold_off: reg_rdata <= {8'h00, overvoltage_threshold};
          overcurrent_threshold_off: reg_rdata <= {8'h00, overcurrent_threshold};
          phase_current_sum_off: reg_rdata <= {4'h0, phase_current_sum};
          sum_mismatch_threshold_off: reg_rdata <= {4'h0, threshold_ext};
          peak_window_count_off: reg_rdata <= 32'(peak_window_count);
          measurement_mode_off: reg_rdata <= {27'h000_0000, peak_phase_select, 2'b00};
          second_status_off: reg_rdata <= second_status_reg;
          second_mask_off: reg_rdata <= second_mask_reg;
          phase_status_off: reg_rdata <= {20'h0_0000, overvoltage_phase_bits, 3'b000,
                                          overcurrent_phase_bits, 3'b000};
          first_status_off: reg_rdata <= {14'h0000, dsp_done_flag, 17'h0_0000};
          default: reg_rdata <= word_zero;
        endcase
      end
    end
  end

endmodule : waveform_peak_and_tamper_monitor

// ### bench/waveform_peak_and_tamper_monitor_props.sv
// property checker bound to the peak and tamper monitor ports
`timescale 1ns/1ps

module waveform_peak_and_tamper_monitor_props #(
  parameter int window_width = 8
) (
  input wire logic clock,
  input wire logic srst,
  input wire peak_tamper_pkg::wave_samples_t samples,
  input wire logic sample_valid,
  input wire logic [2:0] zero_cross,
  input wire peak_tamper_pkg::reg_req_t reg_req,
  input wire logic [31:0] reg_rdata,
  input wire logic reg_rvalid,
  input wire logic event_irq_n
);
  import peak_tamper_pkg::*;

  // -----------------------------------------------------------------
  // read tracking and properties
  // -----------------------------------------------------------------
  // offset of the read being answered, so answers are judged by field
  logic [7:0] read_addr;
  always_ff @(posedge clock) begin
    if (reg_req.rd) begin
      read_addr <= reg_req.addr;
    end
  end

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (srst);

  // no sample and no crossing, so nothing can set a status bit
  sequence s_quiet;
    !sample_valid && zero_cross == 3'b000;
  endsequence
  sequence s_clear(logic [31:0] bits);
    s_quiet ##0 reg_req.wr && reg_req.addr == second_status_off
      && (reg_req.wdata & bits) == bits;
  endsequence

  property p_read_answer; reg_req.rd |=> reg_rvalid; endproperty
  a_read_answer: assert property (p_read_answer) else $error("read not answered");
  property p_unmapped; reg_rvalid && read_addr >= 8'h30 |-> reg_rdata == word_zero; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_thr_pad; reg_rvalid && (read_addr == overvoltage_threshold_off
    || read_addr == overcurrent_threshold_off) |-> reg_rdata[31:24] == 8'h00; endproperty
  a_thr_pad: assert property (p_thr_pad) else $error("threshold top byte set");
  property p_sum_pad; reg_rvalid && read_addr == phase_current_sum_off
    |-> reg_rdata[31:28] == 4'h0; endproperty
  a_sum_pad: assert property (p_sum_pad) else $error("sum top bits set");
  property p_mm_pad; reg_rvalid && read_addr == sum_mismatch_threshold_off
    |-> reg_rdata[31:28] == 4'h0 && reg_rdata[27:24] == {4{reg_rdata[23]}}; endproperty
  a_mm_pad: assert property (p_mm_pad) else $error("mismatch level badly extended");
  property p_peak_tag; reg_rvalid && (read_addr == voltage_peak_result_off
    || read_addr == current_peak_result_off)
    |-> reg_rdata[31:27] == 5'h00 && $onehot0(reg_rdata[26:24]); endproperty
  a_peak_tag: assert property (p_peak_tag) else $error("peak tag not one-hot");
  // the pin may only fall two cycles after something that can set or unmask a bit
  property p_irq_fall; $fell(event_irq_n) |-> $past(sample_valid, 2)
    || $past(zero_cross, 2) != 3'b000 || $past(reg_req.wr, 2); endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("irq fell without cause");
  property p_clear_status; s_clear(32'h0196_0000) ##1 s_quiet ##1
    (reg_req.rd && reg_req.addr == second_status_off) |=> (reg_rdata & 32'h0196_0000) == 0;
  endproperty
  a_clear_status: assert property (p_clear_status) else $error("status not cleared");
  property p_clear_phase; s_clear(32'h0006_0000) ##1 s_quiet ##1
    (reg_req.rd && reg_req.addr == phase_status_off) |=> (reg_rdata & 32'h0000_0E38) == 0;
  endproperty
  a_clear_phase: assert property (p_clear_phase) else $error("phase bits kept");
endmodule : waveform_peak_and_tamper_monitor_props

bind waveform_peak_and_tamper_monitor waveform_peak_and_tamper_monitor_props #(
  .window_width(window_width)
) props_i (
  .clock(clock), .srst(srst), .samples(samples), .sample_valid(sample_valid),
  .zero_cross(zero_cross), .reg_req(reg_req), .reg_rdata(reg_rdata),
  .reg_rvalid(reg_rvalid), .event_irq_n(event_irq_n)
);

// ### bench/host_model.sv
// host microcontroller model issuing word-level register requests
`timescale 1ns/1ps

module host_model (
  input wire logic clock,
  output peak_tamper_pkg::reg_req_t reg_req,
  input wire logic [31:0] reg_rdata,
  input wire logic reg_rvalid
);
  import peak_tamper_pkg::*;

  // reads whose answer never came
  int misses;

  initial begin
    reg_req = '0;
    misses = 0;
  end

  // one-cycle write strobe; released bus shows garbage, not the old word
  task automatic write(input logic [7:0] addr, input logic [31:0] data);
    @(negedge clock);
    reg_req.wr = 1'b1;
    reg_req.addr = addr;
    reg_req.wdata = data;
    @(negedge clock);
    reg_req.wr = 1'b0;
    reg_req.wdata = ~data;
  endtask : write

  // one-cycle read strobe, then a bounded wait for the answer
  task automatic read(input logic [7:0] addr, output logic [31:0] data);
    int k;
    @(negedge clock);
    reg_req.rd = 1'b1;
    reg_req.addr = addr;
    @(negedge clock);
    reg_req.rd = 1'b0;
    reg_req.addr = ~addr;
    for (k = 0; k < 4 && reg_rvalid !== 1'b1; k++) @(negedge clock);
    if (reg_rvalid !== 1'b1) misses++;
    data = reg_rdata;
  endtask : read
endmodule : host_model

// ### bench/tb_waveform_peak_and_tamper_monitor.sv
// self-checking bench for the peak and tamper monitor
`timescale 1ns/1ps

module tb_waveform_peak_and_tamper_monitor;
  import peak_tamper_pkg::*;

  localparam logic [31:0] ones = 32'hFFFF_FFFF;
  localparam logic [31:0] pk = 32'h0180_0000;
  localparam logic [31:0] ph = 32'h0000_0E38;
  logic clock;
  logic srst;
  wave_samples_t samples;
  logic sample_valid;
  logic [2:0] zero_cross;
  reg_req_t reg_req;
  logic [31:0] reg_rdata;
  logic reg_rvalid;
  logic event_irq_n;
  int n_errors;
  int total_checks;

  waveform_peak_and_tamper_monitor #(.window_width(8)) waveform_peak_and_tamper_monitor_i (
    .clock(clock), .srst(srst), .samples(samples), .sample_valid(sample_valid),
    .zero_cross(zero_cross), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .event_irq_n(event_irq_n)
  );
  host_model host_model_i (
    .clock(clock), .reg_req(reg_req), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid)
  );

  // 20 MHz clock
  always #25 clock = ~clock;

  // -----------------------------------------------------------------
  // access and compare tasks
  // -----------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic rc(input logic [7:0] addr, input logic [31:0] mask, input logic [31:0] exp);
    logic [31:0] data;
    host_model_i.read(addr, data);
    chk(data & mask, exp);
  endtask : rc

  task automatic wr(input logic [7:0] addr, input logic [31:0] data);
    host_model_i.write(addr, data);
  endtask : wr

  // one sample set; data lines scrambled after the strobe, then settle
  task automatic smp(input logic [23:0] va, vb, vc, ia, ib, ic, n);
    @(negedge clock);
    samples = {vc, vb, va, ic, ib, ia, n};
    sample_valid = 1'b1;
    @(negedge clock);
    sample_valid = 1'b0;
    samples = ~samples;
    repeat (2) @(negedge clock);
  endtask : smp

  task automatic zc(input logic [2:0] v);
    @(negedge clock);
    zero_cross = v;
    @(negedge clock);
    zero_cross = 3'b000;
    repeat (2) @(negedge clock);
  endtask : zc

  task automatic results;
    n_errors = n_errors + host_model_i.misses;
    $display("checks %0d, errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : results

  // main sequence
  initial begin
    clock = 1'b0;
    srst = 1'b1;
    samples = '0;
    sample_valid = 1'b0;
    zero_cross = 3'b000;
    n_errors = 0;
    total_checks = 0;
    repeat (8) @(negedge clock);
    srst = 1'b0;
    rc(overvoltage_threshold_off, ones, 32'h0051_4791);
    rc(overcurrent_threshold_off, ones, 32'h0051_4791);
    rc(sum_mismatch_threshold_off, ones, word_zero);
    rc(8'h30, ones, word_zero);
    smp('0, '0, '0, '0, '0, '0, '0);
    rc(second_status_off, 32'h0010_0000, 32'h0010_0000);
    wr(sum_mismatch_threshold_off, 32'h007F_FFFF);
    rc(sum_mismatch_threshold_off, ones, 32'h007F_FFFF);
    wr(sum_mismatch_threshold_off, 32'h0080_0000);
    rc(sum_mismatch_threshold_off, ones, 32'h0F80_0000);
    wr(sum_mismatch_threshold_off, 32'h0000_0100);
    wr(second_status_off, ones);
    rc(second_status_off, 32'h0196_0000, word_zero);
    // sum of -20 against a neutral 256 away, then 257 away
    smp('0, '0, '0, 24'h00_000A, 24'h00_0014, 24'hFF_FFCE, 24'h00_0114);
    rc(phase_current_sum_off, ones, 32'h0FFF_FFEC);
    rc(second_status_off, 32'h0010_0000, word_zero);
    rc(first_status_off, 32'h0002_0000, 32'h0002_0000);
    smp('0, '0, '0, 24'h00_000A, 24'h00_0014, 24'hFF_FFCE, 24'h00_0115);
    rc(second_status_off, 32'h0010_0000, 32'h0010_0000);
    // over-level on phase B voltage, current exactly at its threshold
    wr(overvoltage_threshold_off, 32'h0000_1000);
    wr(overcurrent_threshold_off, 32'h0000_1000);
    wr(second_mask_off, 32'h0006_0000);
    wr(second_status_off, ones);
    smp('0, 24'hFF_EFFF, '0, '0, '0, 24'h00_1000, '0);
    chk({31'h0, event_irq_n}, word_zero);
    rc(second_status_off, 32'h0006_0000, 32'h0004_0000);
    rc(phase_status_off, ph, 32'h0000_0400);
    smp('0, '0, '0, '0, '0, 24'h00_1001, '0);
    rc(phase_status_off, ph, 32'h0000_0420);
    wr(second_status_off, word_zero);
    rc(second_status_off, 32'h0006_0000, 32'h0006_0000);
    wr(second_status_off, 32'h0002_0000);
    rc(phase_status_off, ph, 32'h0000_0400);
    chk({31'h0, event_irq_n}, word_zero);
    wr(second_status_off, 32'h0006_0000);
    rc(phase_status_off, ph, word_zero);
    chk({31'h0, event_irq_n}, 32'h0000_0001);
    // threshold zero always detects, full scale misses samples at full scale
    wr(overvoltage_threshold_off, word_zero);
    smp('0, '0, '0, '0, '0, '0, '0);
    rc(second_status_off, 32'h0004_0000, 32'h0004_0000);
    wr(overvoltage_threshold_off, 32'h0051_4791);
    wr(second_status_off, ones);
    smp(24'h51_4791, 24'hAE_B86F, '0, '0, '0, '0, '0);
    rc(second_status_off, 32'h0004_0000, word_zero);
    // peak windows over phases A and B, four enabled crossings
    wr(second_mask_off, pk);
    wr(peak_window_count_off, 32'h0000_0004);
    wr(measurement_mode_off, 32'h0000_000C);
    zc(3'b011);
    wr(second_status_off, ones);
    wr(peak_window_count_off, 32'h0000_0004);
    smp(24'h00_0300, 24'hFF_FB00, 24'h00_7000, 24'hFF_F900, 24'h00_0200, 24'h00_7000, '0);
    zc(3'b011);
    rc(second_status_off, pk, word_zero);
    zc(3'b011);
    chk({31'h0, event_irq_n}, word_zero);
    rc(second_status_off, pk, pk);
    rc(voltage_peak_result_off, ones, 32'h0200_0500);
    rc(current_peak_result_off, ones, 32'h0100_0700);
    wr(second_status_off, pk);
    smp(24'h00_0900, '0, '0, '0, '0, '0, '0);
    zc(3'b011);
    rc(voltage_peak_result_off, ones, 32'h0200_0500);
    zc(3'b001);
    zc(3'b100);
    zc(3'b001);
    rc(voltage_peak_result_off, ones, 32'h0100_0900);
    rc(current_peak_result_off, 32'h00FF_FFFF, word_zero);
    results();
  end
endmodule : tb_waveform_peak_and_tamper_monitor
